// ===== logic/dmacas_top.sv
// four channel dma address, count and shared status registers
// ----------------------------------------------------------------
// Notes on behaviour
// R1: each channel keeps a 24-bit primary base, high byte and low word
// R2: each channel keeps a 24-bit secondary base, split the same way
// R3: each channel keeps a 16-bit read-write peripheral address
// R4: software leaves address and count alone while the channel runs
// R5: 14-bit count; a block moves count plus one transfers
// R6: unused upper bits of high, count and status registers read zero
// R7: most recent ram address, 24 bits, read only, resets to zero
// R8: one sticky peripheral write collision flag per channel, bits 3..0
// R9: request collision flag sets when force meets an interrupt request
// R10: last channel field reads all ones until the first transfer
// R11: ping-pong flag per channel, one means secondary buffer selected
// R12: reset clears addresses, counts and flags, last channel to ones
// R13: direction set reads ram and writes peripheral, clear is reverse
// R14: ping-pong channels swap base address after each block
// R15: two-bit mode selects continuous or one-shot, ping-pong on or off
// R16: force starts one transfer; only hardware clears it (the code also clears it when software clears enable)
// R17: every transfer updates recent address and last channel
// ----------------------------------------------------------------
//
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "dmacas_defines.svh"
module dmacas_top import dmacas_pkg::*; #(
	parameter int NCH = `DMACAS_NCH,
	parameter int CNT_W = `DMACAS_CNT_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// peripheral side events
	input wire logic [3:0] periph_req,
	input wire logic [3:0] periph_wcol,
	// transfer port to the data bus
	output logic xfer_req,
	output logic [23:0] xfer_ram_addr,
	output logic [15:0] xfer_periph_addr,
	output logic xfer_dir,
	output logic [1:0] xfer_chan,
	input wire logic xfer_ack,
	// interrupt
	output logic irq
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] dmacas_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [23:0] dmacas_ram_addr(input logic pp,
		input logic [23:0] pri, input logic [23:0] sec,
		input logic [13:0] idx);
		return (pp ? sec : pri) + {10'h000, idx};
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	dmacas_main_s s_ff;
	dmacas_main_s nxt_s;

	logic [3:0][13:0] idx;
	logic [3:0] pp;
	logic [3:0] done;
	logic [3:0] stop;
	logic [3:0] step;
	logic [3:0] rq_evt;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [31:0] rd_val;
	logic [1:0] acc_ch;
	logic chan_win;
	logic shared_win;
	logic wr_commit;
	logic irq_clr_we;
	logic irq_mask_we;
	logic [31:0] irq_wd;

	assign acc_ch = wb_adr_i[7:6];
	assign chan_win = (wb_adr_i[11:8] == 4'h0);
	assign shared_win = (wb_adr_i[11:8] == `DMACAS_SHARED_PAGE);
	// writes commit on the edge where the master sees ack
	assign wr_commit = wb_cyc_i && wb_stb_i && s_ff.ack && wb_we_i;
	assign irq_clr_we = wr_commit && shared_win &&
		(wb_adr_i[7:0] == `DMACAS_OFS_IRQ_STAT);
	assign irq_mask_we = wr_commit && shared_win &&
		(wb_adr_i[7:0] == `DMACAS_OFS_IRQ_MASK);
	assign irq_wd = dmacas_merge(32'h0, wb_dat_i, wb_sel_i);

	// ----------------------------------------------------------------
	// channel sequencers and interrupt bank
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			assign step[gi] = (s_ff.st == DMACAS_BUSY) && xfer_ack &&
				(s_ff.cur == 2'(gi)) && !s_ff.cur_forced;
			// request collision: force pending meets a peripheral request
			assign rq_evt[gi] = periph_req[gi] && s_ff.en[gi] &&
				s_ff.frc[gi]; // R9
			dmacas_chan #(.CNT_W(CNT_W)) u_chan (
				.clk(clk),
				.rst(rst),
				.en(s_ff.en[gi]),
				.mode(s_ff.mode[gi]),
				.cnt(s_ff.cnt[gi]),
				.step(step[gi]),
				.idx(idx[gi]),
				.pp_sel(pp[gi]),
				.block_done(done[gi]),
				.stop(stop[gi])
			);
		end
	endgenerate

	dmacas_irq #(.W(`DMACAS_IRQ_W)) u_irq (
		.clk(clk),
		.rst(rst),
		.evt({rq_evt, done}),
		.clr_we(irq_clr_we),
		.mask_we(irq_mask_we),
		.wdat(irq_wd[`DMACAS_IRQ_W-1:0]),
		.status(irq_status),
		.mask(irq_mask),
		.irq(irq)
	);

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_val = 32'h0;
		if (chan_win) begin
			case (wb_adr_i[5:0])
				`DMACAS_OFS_CTRL: begin
					rd_val[`DMACAS_BIT_EN] = s_ff.en[acc_ch];
					rd_val[`DMACAS_BIT_DIR] = s_ff.dir[acc_ch];
					rd_val[`DMACAS_MODE_LSB +: 2] = s_ff.mode[acc_ch];
					rd_val[`DMACAS_BIT_FORCE] = s_ff.frc[acc_ch];
				end
				`DMACAS_OFS_PRI_HI: rd_val[7:0] = s_ff.pri[acc_ch][23:16]; // R6
				`DMACAS_OFS_PRI_LO: rd_val[15:0] = s_ff.pri[acc_ch][15:0];
				`DMACAS_OFS_SEC_HI: rd_val[7:0] = s_ff.sec[acc_ch][23:16]; // R6
				`DMACAS_OFS_SEC_LO: rd_val[15:0] = s_ff.sec[acc_ch][15:0];
				`DMACAS_OFS_PAD: rd_val[15:0] = s_ff.pad[acc_ch];
				`DMACAS_OFS_CNT: rd_val[13:0] = s_ff.cnt[acc_ch]; // R6
				default: rd_val = 32'h0;
			endcase
		end else if (shared_win) begin
			case (wb_adr_i[7:0])
				`DMACAS_OFS_RECENT_HI: rd_val[7:0] = s_ff.recent[23:16]; // R7
				`DMACAS_OFS_RECENT_LO: rd_val[15:0] = s_ff.recent[15:0]; // R7
				`DMACAS_OFS_PERIPH_WRITE_COLLISION_FLAG: rd_val[3:0] = s_ff.periph_write_collision_flag; // R8
				`DMACAS_OFS_REQUEST_COLLISION_FLAG: rd_val[3:0] = s_ff.request_collision_flag; // R9
				`DMACAS_OFS_LASTCH: rd_val[3:0] = s_ff.last_ch; // R10
				`DMACAS_OFS_PPSEL: rd_val[3:0] = pp; // R11
				`DMACAS_OFS_IRQ_STAT: rd_val[7:0] = irq_status;
				`DMACAS_OFS_IRQ_MASK: rd_val[7:0] = irq_mask;
				default: rd_val = 32'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] m;
		logic [1:0] pick;
		logic found;
		m = 32'h0;
		pick = 2'h0;
		found = 1'b0;
		nxt_s = s_ff;
		// single cycle wishbone answer, one cycle after the request
		nxt_s.ack = wb_cyc_i && wb_stb_i && !s_ff.ack;
		if (nxt_s.ack) begin
			nxt_s.rdat = rd_val;
		end
		// software writes
		if (wr_commit && chan_win) begin
			case (wb_adr_i[5:0])
				`DMACAS_OFS_CTRL: begin
					m = dmacas_merge({23'h0, s_ff.frc[acc_ch], 2'h0,
						s_ff.mode[acc_ch], 2'h0, s_ff.dir[acc_ch],
						s_ff.en[acc_ch]}, wb_dat_i, wb_sel_i);
					nxt_s.en[acc_ch] = m[`DMACAS_BIT_EN];
					nxt_s.dir[acc_ch] = m[`DMACAS_BIT_DIR]; // R13
					nxt_s.mode[acc_ch] = m[`DMACAS_MODE_LSB +: 2]; // R15
					// software may set force; a zero here keeps it, but clearing enable drops it
					if (m[`DMACAS_BIT_FORCE]) begin
						nxt_s.frc[acc_ch] = 1'b1; // R16
					end
				end
				`DMACAS_OFS_PRI_HI: begin
					m = dmacas_merge({24'h0, s_ff.pri[acc_ch][23:16]},
						wb_dat_i, wb_sel_i);
					nxt_s.pri[acc_ch][23:16] = m[7:0]; // R1
				end
				`DMACAS_OFS_PRI_LO: begin
					m = dmacas_merge({16'h0, s_ff.pri[acc_ch][15:0]},
						wb_dat_i, wb_sel_i);
					nxt_s.pri[acc_ch][15:0] = m[15:0]; // R1
				end
				`DMACAS_OFS_SEC_HI: begin
					m = dmacas_merge({24'h0, s_ff.sec[acc_ch][23:16]},
						wb_dat_i, wb_sel_i);
					nxt_s.sec[acc_ch][23:16] = m[7:0]; // R2
				end
				`DMACAS_OFS_SEC_LO: begin
					m = dmacas_merge({16'h0, s_ff.sec[acc_ch][15:0]},
						wb_dat_i, wb_sel_i);
					nxt_s.sec[acc_ch][15:0] = m[15:0]; // R2
				end
				`DMACAS_OFS_PAD: begin
					// no guard while enabled: that is software's duty
					m = dmacas_merge({16'h0, s_ff.pad[acc_ch]}, wb_dat_i,
						wb_sel_i);
					nxt_s.pad[acc_ch] = m[15:0]; // R3
				end
				`DMACAS_OFS_CNT: begin
					m = dmacas_merge({18'h0, s_ff.cnt[acc_ch]}, wb_dat_i,
						wb_sel_i);
					nxt_s.cnt[acc_ch] = m[13:0]; // R5
				end
				default: nxt_s.cnt = s_ff.cnt;
			endcase
		end
		// peripheral events
		for (int i = 0; i < NCH; i++) begin
			nxt_s.periph_write_collision_flag[i] = s_ff.periph_write_collision_flag[i] | periph_wcol[i]; // R8
			if (rq_evt[i]) begin
				// the forced transfer wins, the request is dropped
				nxt_s.request_collision_flag[i] = 1'b1; // R9
			end else if (periph_req[i] && s_ff.en[i]) begin
				nxt_s.pend[i] = 1'b1;
			end
		end
		// transfer sequencer
		case (s_ff.st)
			DMACAS_IDLE: begin
				// fixed priority, lowest channel first
				for (int i = NCH - 1; i >= 0; i--) begin
					if (s_ff.en[i] && (s_ff.pend[i] || s_ff.frc[i])) begin
						pick = 2'(i);
						found = 1'b1;
					end
				end
				if (found) begin
					nxt_s.cur = pick;
					nxt_s.cur_forced = !s_ff.pend[pick];
					nxt_s.xreq = 1'b1;
					nxt_s.xram = dmacas_ram_addr(pp[pick], s_ff.pri[pick],
						s_ff.sec[pick], idx[pick]); // R11
					nxt_s.xpad = s_ff.pad[pick];
					nxt_s.xdir = s_ff.dir[pick]; // R13
					nxt_s.st = DMACAS_BUSY;
				end
			end
			DMACAS_BUSY: begin
				if (xfer_ack) begin
					nxt_s.xreq = 1'b0;
					nxt_s.recent = s_ff.xram; // R17
					nxt_s.last_ch = {2'h0, s_ff.cur}; // R17
					if (s_ff.cur_forced) begin
						nxt_s.frc[s_ff.cur] = 1'b0; // R16
					end else begin
						nxt_s.pend[s_ff.cur] = 1'b0;
					end
					nxt_s.st = DMACAS_IDLE;
				end
			end
			default: nxt_s.st = DMACAS_IDLE;
		endcase
		// one-shot end and disable
		for (int i = 0; i < NCH; i++) begin
			if (stop[i]) begin
				nxt_s.en[i] = 1'b0; // R15
			end
			if (!nxt_s.en[i]) begin
				nxt_s.frc[i] = 1'b0; // R16
				nxt_s.pend[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_ff <= '0; // R12
			s_ff.st <= DMACAS_IDLE;
			s_ff.last_ch <= `DMACAS_LASTCH_NONE; // R12
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_dat_o = s_ff.rdat;
	assign wb_ack_o = s_ff.ack;
	assign xfer_req = s_ff.xreq;
	assign xfer_ram_addr = s_ff.xram;
	assign xfer_periph_addr = s_ff.xpad;
	assign xfer_dir = s_ff.xdir;
	assign xfer_chan = s_ff.cur;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_lastch_legal: assert property ( // R10
		s_ff.last_ch == `DMACAS_LASTCH_NONE ||
		s_ff.last_ch[3:2] == 2'h0)
		else $error("last channel holds a reserved code");
	a_recent_update: assert property ( // R17
		s_ff.st == DMACAS_BUSY && xfer_ack
		|=> s_ff.recent == $past(s_ff.xram) &&
		s_ff.last_ch == {2'h0, $past(s_ff.cur)})
		else $error("recent address or last channel not updated");
	a_ram_addr_sel: assert property ($rose(s_ff.xreq) |-> // R11
		s_ff.xram == dmacas_ram_addr(pp[s_ff.cur], s_ff.pri[s_ff.cur],
		s_ff.sec[s_ff.cur], idx[s_ff.cur]))
		else $error("ram address not from selected base");
	a_dir_follow: assert property ($rose(s_ff.xreq) |-> // R13
		xfer_dir == s_ff.dir[s_ff.cur])
		else $error("transfer direction differs from channel");
	a_force_hold: assert property ( // R16
		!wr_commit && !(s_ff.st == DMACAS_BUSY && xfer_ack &&
		s_ff.cur_forced) |=>
		(s_ff.frc & $past(s_ff.frc & s_ff.en & ~stop)) ==
		$past(s_ff.frc & s_ff.en & ~stop))
		else $error("force cleared without completion");
	a_request_collision_flag_set: assert property ( // R9
		(s_ff.request_collision_flag | rq_evt) != 4'h0 |=>
		(s_ff.request_collision_flag & $past(s_ff.request_collision_flag | rq_evt)) ==
		$past(s_ff.request_collision_flag | rq_evt))
		else $error("request collision not flagged");
	a_periph_write_collision_flag_sticky: assert property ( // R8
		(s_ff.periph_write_collision_flag | periph_wcol) != 4'h0 |=>
		(s_ff.periph_write_collision_flag & $past(s_ff.periph_write_collision_flag | periph_wcol)) ==
		$past(s_ff.periph_write_collision_flag | periph_wcol))
		else $error("write collision flag not held");
	a_oneshot_stop: assert property ( // R15
		stop != 4'h0 |=> (s_ff.en & $past(stop)) == 4'h0)
		else $error("one-shot channel still enabled");
	a_status_upper: assert property ( // R6
		wb_ack_o && shared_win && wb_adr_i[7:0] == `DMACAS_OFS_LASTCH
		|-> wb_dat_o[31:4] == 28'h0)
		else $error("status upper bits not zero");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	c_transfer: cover property (s_ff.st == DMACAS_BUSY && xfer_ack);
	c_rq_collision: cover property (rq_evt != 4'h0);
	c_irq: cover property ($rose(irq));
	c_oneshot_end: cover property (stop != 4'h0);
endmodule

// ===== logic/dmacas_defines.svh
// register map, field positions and reset values of the dma address block
`ifndef DMACAS_DEFINES_SVH
`define DMACAS_DEFINES_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define DMACAS_NCH 4
`define DMACAS_ADDR_W 24
`define DMACAS_PAD_W 16
`define DMACAS_CNT_W 14

// ----------------------------------------------------------------
// per channel window: adr[11:9]=0, adr[8]=0, adr[7:6]=channel
// ----------------------------------------------------------------
`define DMACAS_OFS_CTRL 6'h00
`define DMACAS_OFS_PRI_HI 6'h04
`define DMACAS_OFS_PRI_LO 6'h08
`define DMACAS_OFS_SEC_HI 6'h0c
`define DMACAS_OFS_SEC_LO 6'h10
`define DMACAS_OFS_PAD 6'h14
`define DMACAS_OFS_CNT 6'h18

// ----------------------------------------------------------------
// shared window: adr[11:8]=1
// ----------------------------------------------------------------
`define DMACAS_SHARED_PAGE 4'h1
`define DMACAS_OFS_RECENT_HI 8'h00
`define DMACAS_OFS_RECENT_LO 8'h04
`define DMACAS_OFS_PERIPH_WRITE_COLLISION_FLAG 8'h08
`define DMACAS_OFS_REQUEST_COLLISION_FLAG 8'h0c
`define DMACAS_OFS_LASTCH 8'h10
`define DMACAS_OFS_PPSEL 8'h14
`define DMACAS_OFS_IRQ_STAT 8'h18
`define DMACAS_OFS_IRQ_MASK 8'h1c

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define DMACAS_BIT_EN 0
`define DMACAS_BIT_DIR 1
`define DMACAS_MODE_LSB 4
`define DMACAS_BIT_FORCE 8

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define DMACAS_LASTCH_NONE 4'hf
`define DMACAS_MODE_ONESHOT 2'h1
`define DMACAS_MODE_ONESHOT_PP 2'h3
`define DMACAS_IRQ_W 8

`endif

// ===== logic/dmacas_pkg.sv
// types shared by the dma address and status block
package dmacas_pkg;

	typedef enum logic [1:0] {
		DMACAS_IDLE = 2'b01,
		DMACAS_BUSY = 2'b10
	} dmacas_state_e;

	typedef struct packed {
		dmacas_state_e st;
		logic [3:0] en;
		logic [3:0] dir;
		logic [3:0] frc;
		logic [3:0] pend;
		logic [3:0] periph_write_collision_flag;
		logic [3:0] request_collision_flag;
		logic [3:0][1:0] mode;
		logic [3:0][23:0] pri;
		logic [3:0][23:0] sec;
		logic [3:0][15:0] pad;
		logic [3:0][13:0] cnt;
		logic [23:0] recent;
		logic [3:0] last_ch;
		logic [1:0] cur;
		logic cur_forced;
		logic ack;
		logic [31:0] rdat;
		logic xreq;
		logic [23:0] xram;
		logic [15:0] xpad;
		logic xdir;
	} dmacas_main_s;

endpackage

// ===== logic/dmacas_chan.sv
// per channel block position and ping-pong buffer selection
`timescale 1ns/1ps
`include "dmacas_defines.svh"
module dmacas_chan import dmacas_pkg::*; #(
	parameter int CNT_W = `DMACAS_CNT_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// channel setup
	input wire logic en,
	input wire logic [1:0] mode,
	input wire logic [CNT_W-1:0] cnt,
	// transfer completion
	input wire logic step,
	// position and block status
	output logic [CNT_W-1:0] idx,
	output logic pp_sel,
	output logic block_done,
	output logic stop
);
	typedef struct packed {
		logic [CNT_W-1:0] idx;
		logic pp;
	} dmacas_chan_s;

	dmacas_chan_s s_ff;
	dmacas_chan_s nxt_s;

	// one extra transfer: the block ends when idx equals cnt
	assign block_done = step && (s_ff.idx == cnt); // R5
	// one-shot stops after one block, or after the second buffer
	assign stop = block_done && ((mode == `DMACAS_MODE_ONESHOT) ||
		(mode == `DMACAS_MODE_ONESHOT_PP && s_ff.pp)); // R15
	assign idx = s_ff.idx;
	assign pp_sel = s_ff.pp;

	always_comb begin
		nxt_s = s_ff;
		if (!en) begin
			// a fresh enable restarts from the primary buffer
			nxt_s = '0;
		end else if (block_done) begin
			nxt_s.idx = '0;
			if (mode[1]) begin
				nxt_s.pp = ~s_ff.pp; // R14
			end
		end else if (step) begin
			nxt_s.idx = s_ff.idx + 1'b1; // R5
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_block_wrap: assert property (block_done && en |=> s_ff.idx == '0) // R5
		else $error("index did not wrap at block end");
	a_pp_toggle: assert property (block_done && en && mode[1] // R14
		|=> s_ff.pp != $past(s_ff.pp))
		else $error("ping-pong buffer did not switch");
	c_pp_switch: cover property (block_done && mode[1]);
endmodule

// ===== logic/dmacas_irq.sv
// sticky event status with mask and level interrupt
`timescale 1ns/1ps
`include "dmacas_defines.svh"
module dmacas_irq import dmacas_pkg::*; #(
	parameter int W = `DMACAS_IRQ_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// events
	input wire logic [W-1:0] evt,
	// software access
	input wire logic clr_we,
	input wire logic mask_we,
	input wire logic [W-1:0] wdat,
	// state
	output logic [W-1:0] status,
	output logic [W-1:0] mask,
	output logic irq
);
	typedef struct packed {
		logic [W-1:0] status;
		logic [W-1:0] mask;
	} dmacas_irq_s;

	dmacas_irq_s s_ff;
	dmacas_irq_s nxt_s;

	always_comb begin
		nxt_s = s_ff;
		if (clr_we) begin
			nxt_s.status = s_ff.status & ~wdat;
		end
		if (mask_we) begin
			nxt_s.mask = wdat;
		end
		// an event in the clearing cycle is kept
		nxt_s.status = nxt_s.status | evt;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign status = s_ff.status;
	assign mask = s_ff.mask;
	assign irq = |(s_ff.status & s_ff.mask);
endmodule

// ===== bench/dmacas_bus_model.sv
// data bus model that answers transfer requests after a random wait
`timescale 1ns/1ps
module dmacas_bus_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// transfer handshake
	input wire logic xfer_req,
	output logic xfer_ack
);
	// ----------------------------------------------------------------
	// ack after 0..3 wait cycles, one cycle wide
	// ----------------------------------------------------------------
	int wait_n;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			xfer_ack <= 1'b0;
			wait_n <= 0;
		end else if (xfer_ack) begin
			xfer_ack <= 1'b0;
			wait_n <= $urandom_range(0, 3);
		end else if (xfer_req && wait_n == 0) begin
			xfer_ack <= 1'b1;
		end else if (xfer_req) begin
			wait_n <= wait_n - 1;
		end
	end
endmodule

// ===== bench/tb.sv
// self-checking bench of the dma address and status block
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		checked++; \
		if ((got) !== (exp)) begin \
			n_fail++; \
			$display("wrong value at %0t: got %h expected %h", \
				$time, got, exp); \
		end \
	end
module tb;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [11:0] wb_adr_i;
	logic [3:0] wb_sel_i, periph_req, periph_wcol, w;
	logic [31:0] wb_dat_i, wb_dat_o, q, v;
	logic xfer_req, xfer_dir, xfer_ack, irq, d;
	logic [23:0] xfer_ram_addr, ra;
	logic [15:0] xfer_periph_addr;
	logic [1:0] xfer_chan, c, c2;
	logic [13:0] cnt;
	logic [23:0] pri[4], sec[4];
	logic [15:0] pad[4];
	int n_fail = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] msk[7] = '{32'h0, 32'hff, 32'hffff, 32'hff, 32'hffff,
		32'hffff, 32'h3fff};

	dmacas_top dmacas_top_i (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .periph_req(periph_req),
		.periph_wcol(periph_wcol), .xfer_req(xfer_req),
		.xfer_ram_addr(xfer_ram_addr), .xfer_periph_addr(xfer_periph_addr),
		.xfer_dir(xfer_dir), .xfer_chan(xfer_chan), .xfer_ack(xfer_ack),
		.irq(irq));
	dmacas_bus_model dmacas_bus_model_i (.clk(clk), .rst(rst),
		.xfer_req(xfer_req), .xfer_ack(xfer_ack));

	// ----------------------------------------------------------------
	// tasks and expectations
	// ----------------------------------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// entered just after a rising edge; holds the request until ack
	task automatic wb(input logic we, input logic [11:0] a,
		input logic [31:0] dt, output logic [31:0] rq);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'hf;
		wb_adr_i <= a;
		wb_dat_i <= dt;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) n_fail++;
		rq = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask

	task automatic kick(input logic [1:0] ch);
		periph_req <= 4'h1 << ch;
		@(posedge clk);
		periph_req <= 4'h0;
	endtask

	task automatic xfer_chk(input logic [1:0] ch, input logic [23:0] r,
		input logic [15:0] p, input logic dr);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!(xfer_req === 1'b1 && xfer_ack === 1'b1) && n < 100);
		if (n >= 100) n_fail++;
		`CHK(xfer_ram_addr, r)
		`CHK(xfer_periph_addr, p)
		`CHK(xfer_dir, dr)
		`CHK(xfer_chan, ch)
	endtask

	function automatic logic [11:0] adr(input int ch, input int k);
		return 12'(ch * 64 + k * 4);
	endfunction

	// ram address of transfer i within block blk (ping-pong alternates)
	function automatic logic [23:0] exp_ram(input logic [1:0] ch,
		input int blk, input int i);
		return ((blk % 2) ? sec[ch] : pri[ch]) + 24'(i);
	endfunction

	// ----------------------------------------------------------------
	// clock, timeout
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 12'h0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		periph_req = 4'h0;
		periph_wcol = 4'h0;
		v = $urandom(59);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int k = 1; k < 7; k++) rd(adr(0, k), 32'h0);
		for (int k = 0; k < 8; k++) rd(12'h100 + 12'(k * 4),
			(k == 4) ? 32'hf : 32'h0);
		$display("test reset values done");
		// all channels disabled here, so address writes are allowed
		for (int ch = 0; ch < 4; ch++) begin
			for (int k = 1; k < 7; k++) begin
				v = $urandom();
				wb(1'b1, adr(ch, k), v, q);
				rd(adr(ch, k), v & msk[k]);
				case (k)
					1: pri[ch][23:16] = v[7:0];
					2: pri[ch][15:0] = v[15:0];
					3: sec[ch][23:16] = v[7:0];
					4: sec[ch][15:0] = v[15:0];
					5: pad[ch] = v[15:0];
					default: ;
				endcase
			end
		end
		wb(1'b1, 12'h100, $urandom(), q);
		rd(12'h100, 32'h0);
		wb(1'b1, 12'h200, $urandom(), q);
		rd(12'h200, 32'h0);
		$display("test register access done");
		c = 2'($urandom_range(0, 3));
		c2 = c + 2'h1;
		d = 1'($urandom_range(0, 1));
		cnt = 14'($urandom_range(0, 2));
		wb(1'b1, adr(c, 6), 32'(cnt), q);
		wb(1'b1, adr(c, 0), 32'h21 | (32'(d) << 1), q);
		for (int b = 0; b < 2; b++) begin
			for (int i = 0; i <= int'(cnt); i++) begin
				kick(c);
				xfer_chk(c, exp_ram(c, b, i), pad[c], d);
				@(posedge clk);
			end
			rd(12'h114, b ? 32'h0 : 32'(4'h1 << c));
			if (b == 0) begin
				rd(12'h118, 32'(4'h1 << c));
				`CHK(irq, 1'b0)
				wb(1'b1, 12'h11c, 32'(4'h1 << c), q);
				`CHK(irq, 1'b1)
				wb(1'b1, 12'h118, 32'(4'h1 << c), q);
				`CHK(irq, 1'b0)
			end
		end
		ra = exp_ram(c, 1, int'(cnt));
		rd(12'h100, 32'(ra[23:16]));
		rd(12'h104, 32'(ra[15:0]));
		rd(12'h110, 32'(c));
		wb(1'b0, adr(c, 0), 32'h0, q);
		`CHK(q[0], 1'b1)
		$display("test ping-pong transfers done");
		wb(1'b1, adr(c, 0), 32'h0, q);
		wb(1'b1, adr(c2, 0), 32'h1, q);
		wb(1'b1, adr(c2, 0), 32'h101, q);
		kick(c2);
		xfer_chk(c2, pri[c2], pad[c2], 1'b0);
		repeat (6) @(posedge clk);
		`CHK(xfer_req, 1'b0)
		wb(1'b0, adr(c2, 0), 32'h0, q);
		`CHK(q[8], 1'b0)
		rd(12'h10c, 32'(4'h1 << c2));
		rd(12'h110, 32'(c2));
		rd(12'h118, 32'((8'h1 << c) | (8'h10 << c2)));
		$display("test force and request collision done");
		// one-shot, or one-shot ping-pong when d is set
		wb(1'b1, adr(c, 0), 32'h11 | (32'(d) << 5) | (32'(!d) << 1), q);
		for (int b = 0; b <= int'(d); b++) begin
			for (int i = 0; i <= int'(cnt); i++) begin
				kick(c);
				xfer_chk(c, exp_ram(c, b, i), pad[c], !d);
				@(posedge clk);
			end
		end
		wb(1'b0, adr(c, 0), 32'h0, q);
		`CHK(q[0], 1'b0)
		$display("test one-shot done");
		w = 4'($urandom_range(1, 15));
		periph_wcol <= w;
		@(posedge clk);
		periph_wcol <= 4'h0;
		@(posedge clk);
		rd(12'h108, 32'(w));
		$display("test write collision done");
		final_report();
	end
endmodule
